/* File: pkg/spe_map.vh */
// spe_map.vh: register offsets, field positions and reset values
// for the port internal error and time-out register block.
// included by bare name; holds definitions only.
`ifndef SPE_MAP_VH
`define SPE_MAP_VH
`define SPE_OFF_PAR_CTL 12'h4D4
`define SPE_OFF_ERR_STS 12'h4D8
`define SPE_OFF_ERR_CTL 12'h4DC
`define SPE_OFF_ERR_CNT 12'h4E0
`define SPE_OFF_TO_CTL 12'h4E4
`define SPE_OFF_TO_RCTL 12'h4E8
`define SPE_OFF_TO_CNT 12'h4EC
`define SPE_OFF_TO_STS 12'h4F0
`define SPE_OFF_IRQ_STS 12'h4F4
`define SPE_OFF_IRQ_MASK 12'h4F8
`define SPE_RST_ERR_CTL 3'h2
`define SPE_RST_TO_CTL 1'h1
`define SPE_RST_TO_RCTL 6'h02
`define SPE_SEV_NONE 2'h0
`define SPE_SEV_COR 2'h1
`define SPE_SEV_NONFATAL 2'h2
`define SPE_SEV_FATAL 2'h3
`define SPE_IRQ_PARITY 0
`define SPE_IRQ_P_TO 1
`define SPE_IRQ_NP_TO 2
`define SPE_IRQ_CPL_TO 3
`endif

/* File: logic/spe_sat_cnt.v */
// spe_sat_cnt.v: saturating counter with clear-on-read.
// assumes inc and clr are one-cycle pulses in the ref_clk domain.
`timescale 1ns/1ns
module spe_sat_cnt #(
  parameter W = 8
) (
  input wire ref_clk, // core clock
  input wire rst, // synchronous reset, active high
  input wire inc, // count one event
  input wire clr, // read seen, clear to zero, or to one with inc
  output reg [W-1:0] count_q // current count
);
  // an event in the read cycle is kept as one, so nothing is lost
  always @(posedge ref_clk) begin
    if (rst) begin
      count_q <= {W{1'b0}};
    end else if (clr) begin
      count_q <= {{(W-1){1'b0}}, inc};
    end else if (inc && !(&count_q)) begin
      count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // spe_sat_cnt

/* File: logic/spe_msg_arb.v */
// spe_msg_arb.v: queues pending error message requests by source, each tagged with its severity,
// and hands one message at a time to the upstream port.
// assumes the port answers msg_valid with a one-cycle msg_ack.
`timescale 1ns/1ns
module spe_msg_arb (
  input wire ref_clk, // core clock
  input wire rst, // synchronous reset, active high
  input wire [3:0] req_sev, // per-source request pulse, one bit per source
  input wire [7:0] req_code, // two-bit severity per source
  input wire msg_ack, // port took the message
  output reg msg_valid_q, // message request pending
  output reg [1:0] msg_sev_q // 1 cor, 2 nonfatal, 3 fatal
);
  reg [3:0] pend_q;
  reg [7:0] code_q;
  reg [1:0] sel;
  reg found;
  integer i;
  // own index for the clocked loop, so the two processes share no variable
  integer j;
  // lowest source index wins; each source holds one pending message
  always @* begin
    sel = 2'h0;
    found = 1'b0;
    for (i = 3; i >= 0; i = i - 1) begin
      if (pend_q[i]) begin
        sel = i[1:0];
        found = 1'b1;
      end
    end
  end
  always @(posedge ref_clk) begin
    if (rst) begin
      pend_q <= 4'h0;
      code_q <= 8'h00;
      msg_valid_q <= 1'b0;
      msg_sev_q <= 2'h0;
    end else begin
      if (msg_valid_q && msg_ack) begin
        msg_valid_q <= 1'b0;
      end else if (!msg_valid_q && found) begin
        msg_valid_q <= 1'b1;
        msg_sev_q <= code_q[sel*2 +: 2];
        pend_q[sel] <= 1'b0;
      end
      for (j = 0; j < 4; j = j + 1) begin
        if (req_sev[j]) begin
          pend_q[j] <= 1'b1;
          code_q[j*2 +: 2] <= req_code[j*2 +: 2];
        end
      end
    end
  end
endmodule // spe_msg_arb

/* File: logic/spe_regs.v */
// spe_regs.v: per-port internal error and switch time-out registers.
// assumes an APB master in the ref_clk domain and event pulses from
// the parity checker and ingress queues, all synchronous to ref_clk.
//
// Function
// - parity error sets flag; write one clears
// - parity report field picks message, reset nonfatal
// - parity report only on flag rising edge
// - parity irq enable plus port enable sends interrupt
// - eight-bit parity counter saturates at 0xFF
// - reading parity counter returns value then clears
// - timeout enable gates stale TLP discard
// - posted timeout report field, reset nonfatal
// - nonposted timeout report field, reset none
// - completion timeout report field, reset none
// - timeout report only on status rising edge
// - saturating clear-on-read discard counters 8/8/9
// - parity check disable blocks flag and count
`timescale 1ns/1ns
`include "spe_map.vh"
module spe_regs (
  input wire ref_clk, // core clock, 125 MHz
  input wire rst, // synchronous reset, active high
  input wire [11:0] paddr, // apb byte address
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error, unmapped address
  input wire parity_err, // end-to-end parity error pulse
  input wire p_stale, // posted head TLP past time-out limit
  input wire np_stale, // nonposted head TLP past limit
  input wire cpl_stale, // completion head TLP past limit
  input wire port_irq_en, // upstream interrupt or msi enabled
  input wire msg_ack, // upstream port took a message
  input wire int_ack, // upstream port took the interrupt tlp
  output reg p_discard, // discard posted head TLP
  output reg np_discard, // discard nonposted head TLP
  output reg cpl_discard, // discard completion head TLP
  output reg msg_valid, // error message request
  output reg [1:0] msg_sev, // message severity code
  output reg int_req, // interrupt or msi tlp request
  output reg irq // level interrupt to local software
);
  reg par_chk_dis_q;
  reg err_flag_q;
  reg [2:0] err_ctl_q;
  reg to_en_q;
  reg [5:0] to_rctl_q;
  reg [2:0] to_sts_q;
  reg [3:0] irq_sts_q;
  reg [3:0] irq_mask_q;
  reg [31:0] rdata_d;
  reg hit;
  reg [3:0] req_vec;
  reg [7:0] req_code;
  wire wr_en;
  wire rd_en;
  wire par_hit;
  wire [2:0] disc;
  wire [2:0] to_rise;
  wire [7:0] par_cnt;
  wire [7:0] p_cnt;
  wire [7:0] np_cnt;
  wire [8:0] cpl_cnt;
  wire arb_valid;
  wire [1:0] arb_sev;
  wire cnt_rd;
  wire to_cnt_rd;

  // access takes effect in the first access-phase cycle; pready rises one cycle later
  assign wr_en = psel && penable && pwrite && !pready;
  assign rd_en = psel && penable && !pwrite && !pready;
  assign cnt_rd = rd_en && (paddr == `SPE_OFF_ERR_CNT);
  assign to_cnt_rd = rd_en && (paddr == `SPE_OFF_TO_CNT);

  // checking is skipped entirely while disabled
  assign par_hit = parity_err && !par_chk_dis_q;
  // a stale TLP is only dropped while time-outs are enabled
  assign disc = {cpl_stale, np_stale, p_stale} & {3{to_en_q}};
  assign to_rise = disc & ~to_sts_q;

  // apb slave: one wait state per access, pslverr on unmapped address
  always @(posedge ref_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit;
      if (rd_en) begin
        prdata <= rdata_d;
      end
    end
  end

  // read mux; reserved bits read as zero
  always @* begin
    rdata_d = 32'h00000000;
    hit = 1'b1;
    case (paddr)
      `SPE_OFF_PAR_CTL: rdata_d = {31'h0, par_chk_dis_q};
      `SPE_OFF_ERR_STS: rdata_d = {31'h0, err_flag_q};
      `SPE_OFF_ERR_CTL: rdata_d = {29'h0, err_ctl_q};
      `SPE_OFF_ERR_CNT: rdata_d = {24'h0, par_cnt};
      `SPE_OFF_TO_CTL: rdata_d = {31'h0, to_en_q};
      `SPE_OFF_TO_RCTL: rdata_d = {26'h0, to_rctl_q};
      `SPE_OFF_TO_CNT: rdata_d = {7'h0, cpl_cnt, np_cnt, p_cnt};
      `SPE_OFF_TO_STS: rdata_d = {29'h0, to_sts_q};
      `SPE_OFF_IRQ_STS: rdata_d = {28'h0, irq_sts_q};
      `SPE_OFF_IRQ_MASK: rdata_d = {28'h0, irq_mask_q};
      default: hit = 1'b0;
    endcase
  end

  // control registers
  always @(posedge ref_clk) begin
    if (rst) begin
      par_chk_dis_q <= 1'b0;
      err_ctl_q <= `SPE_RST_ERR_CTL;
      to_en_q <= `SPE_RST_TO_CTL;
      to_rctl_q <= `SPE_RST_TO_RCTL;
      irq_mask_q <= 4'h0;
    end else if (wr_en) begin
      case (paddr)
        `SPE_OFF_PAR_CTL: par_chk_dis_q <= pwdata[0];
        `SPE_OFF_ERR_CTL: err_ctl_q <= pwdata[2:0];
        `SPE_OFF_TO_CTL: to_en_q <= pwdata[0];
        `SPE_OFF_TO_RCTL: to_rctl_q <= pwdata[5:0];
        `SPE_OFF_IRQ_MASK: irq_mask_q <= pwdata[3:0];
        default: to_en_q <= to_en_q;
      endcase
    end
  end

  // sticky status: a new event beats a write-one clear in the same cycle
  always @(posedge ref_clk) begin
    if (rst) begin
      err_flag_q <= 1'b0;
      to_sts_q <= 3'h0;
      irq_sts_q <= 4'h0;
    end else begin
      if (par_hit) begin
        err_flag_q <= 1'b1;
      end else if (wr_en && paddr == `SPE_OFF_ERR_STS && pwdata[0]) begin
        err_flag_q <= 1'b0;
      end
      if (wr_en && paddr == `SPE_OFF_TO_STS) begin
        to_sts_q <= (to_sts_q & ~pwdata[2:0]) | disc;
      end else begin
        to_sts_q <= to_sts_q | disc;
      end
      if (wr_en && paddr == `SPE_OFF_IRQ_STS) begin
        irq_sts_q <= (irq_sts_q & ~pwdata[3:0]) | {to_rise, par_hit};
      end else begin
        irq_sts_q <= irq_sts_q | {to_rise, par_hit};
      end
    end
  end

  // message requests fire on the zero-to-one edge of each status bit only
  always @* begin
    req_vec[`SPE_IRQ_PARITY] = par_hit && !err_flag_q &&
      (err_ctl_q[1:0] != `SPE_SEV_NONE);
    req_vec[`SPE_IRQ_P_TO] = to_rise[0] && (to_rctl_q[1:0] != `SPE_SEV_NONE);
    req_vec[`SPE_IRQ_NP_TO] = to_rise[1] && (to_rctl_q[3:2] != `SPE_SEV_NONE);
    req_vec[`SPE_IRQ_CPL_TO] = to_rise[2] && (to_rctl_q[5:4] != `SPE_SEV_NONE);
    req_code = {to_rctl_q, err_ctl_q[1:0]};
  end

  spe_msg_arb u_arb (
    .ref_clk(ref_clk),
    .rst(rst),
    .req_sev(req_vec),
    .req_code(req_code),
    .msg_ack(msg_ack),
    .msg_valid_q(arb_valid),
    .msg_sev_q(arb_sev)
  );

  spe_sat_cnt #(.W(8)) u_par_cnt (
    .ref_clk(ref_clk),
    .rst(rst),
    .inc(par_hit),
    .clr(cnt_rd),
    .count_q(par_cnt)
  );

  spe_sat_cnt #(.W(8)) u_p_cnt (
    .ref_clk(ref_clk),
    .rst(rst),
    .inc(disc[0]),
    .clr(to_cnt_rd),
    .count_q(p_cnt)
  );

  spe_sat_cnt #(.W(8)) u_np_cnt (
    .ref_clk(ref_clk),
    .rst(rst),
    .inc(disc[1]),
    .clr(to_cnt_rd),
    .count_q(np_cnt)
  );

  spe_sat_cnt #(.W(9)) u_cpl_cnt (
    .ref_clk(ref_clk),
    .rst(rst),
    .inc(disc[2]),
    .clr(to_cnt_rd),
    .count_q(cpl_cnt)
  );

  // outputs registered; message ack is passed to the arbiter directly
  always @(posedge ref_clk) begin
    if (rst) begin
      p_discard <= 1'b0;
      np_discard <= 1'b0;
      cpl_discard <= 1'b0;
      msg_valid <= 1'b0;
      msg_sev <= 2'h0;
      int_req <= 1'b0;
      irq <= 1'b0;
    end else begin
      p_discard <= disc[0];
      np_discard <= disc[1];
      cpl_discard <= disc[2];
      msg_valid <= arb_valid && !(msg_valid && msg_ack);
      msg_sev <= arb_sev;
      // interrupt tlp held until the port accepts it
      if (par_hit && err_ctl_q[2] && port_irq_en) begin
        int_req <= 1'b1;
      end else if (int_ack) begin
        int_req <= 1'b0;
      end
      irq <= |(irq_sts_q & irq_mask_q);
    end
  end
endmodule // spe_regs

/* File: bench/spe_root_model.sv */
// spe_root_model.sv: root side taking error messages and interrupt tlps.
// assumes level requests held until a one-cycle ack; lag sets the message ack delay.
`timescale 1ns/1ns
module spe_root (
  input wire ref_clk, // core clock
  input wire rst, // sync reset
  input wire msg_valid, // message request
  input wire [1:0] msg_sev, // message severity
  input wire int_req, // interrupt tlp request
  input wire [3:0] lag, // cycles before the message ack
  output reg msg_ack, // message taken
  output reg int_ack, // interrupt taken
  output reg [7:0] msg_cnt, // messages taken
  output reg [7:0] int_cnt, // interrupts taken
  output reg [1:0] last_sev // severity of last message
);
  reg [3:0] wait_q;
  // ack never twice for one request: the design drops it a cycle after ack
  always @(posedge ref_clk) begin
    if (rst) begin
      msg_ack <= 1'h0;
      int_ack <= 1'h0;
      wait_q <= 4'h0;
      msg_cnt <= 8'h00;
      int_cnt <= 8'h00;
      last_sev <= 2'h0;
    end else begin
      msg_ack <= msg_valid && !msg_ack && (wait_q >= lag);
      int_ack <= int_req && !int_ack;
      if (msg_valid && !msg_ack && wait_q >= lag) begin
        msg_cnt <= msg_cnt + 8'h01;
        last_sev <= msg_sev;
        wait_q <= 4'h0;
      end else if (msg_valid && !msg_ack) begin
        wait_q <= wait_q + 4'h1;
      end
      if (int_req && !int_ack) begin
        int_cnt <= int_cnt + 8'h01;
      end
    end
  end
endmodule // spe_root

/* File: bench/spe_regs_chk_sva.sv */
// spe_regs_chk_sva.sv: port checks for the error register block.
// assumes one clock ref_clk and sync reset rst.
`timescale 1ns/1ns
module spe_regs_chk (
  input wire ref_clk, // core clock
  input wire rst, // sync reset, active high
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pready, // apb ready
  input wire p_stale, // posted head TLP stale
  input wire np_stale, // nonposted head TLP stale
  input wire p_discard, // posted discard
  input wire np_discard, // nonposted discard
  input wire parity_err, // parity error pulse
  input wire msg_valid, // message request
  input wire [1:0] msg_sev, // message severity
  input wire msg_ack, // message taken
  input wire int_req, // interrupt tlp request
  input wire int_ack // interrupt taken
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // one wait state, one-cycle ready
  property p_rdy; psel && penable && !pready |=> pready; endproperty
  property p_rdy1; pready |=> !pready; endproperty
  property p_sev; $rose(msg_valid) |-> msg_sev != 2'h0; endproperty
  property p_hold; msg_valid && !msg_ack |=> msg_valid && $stable(msg_sev); endproperty
  property p_intc; $rose(int_req) |-> $past(parity_err) || $past(parity_err, 2); endproperty
  property p_inth; int_req && !int_ack |=> int_req; endproperty
  property p_pd; p_discard |-> $past(p_stale); endproperty
  property p_npd; np_discard |-> $past(np_stale); endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  a_rdy1: assert property (p_rdy1) else $error("ready too long");
  a_sev: assert property (p_sev) else $error("empty message");
  a_hold: assert property (p_hold) else $error("message dropped");
  a_intc: assert property (p_intc) else $error("stray interrupt");
  a_inth: assert property (p_inth) else $error("interrupt dropped");
  a_pd: assert property (p_pd) else $error("stray posted discard");
  a_npd: assert property (p_npd) else $error("stray nonposted discard");
  c_msg: cover property (msg_valid && msg_ack);
  c_drop: cover property (p_discard);
  c_int: cover property (int_req && int_ack);
endmodule // spe_regs_chk
bind spe_regs spe_regs_chk spe_regs_chk_inst (.*);

/* File: bench/switch_port_error_timeout_regs_test.sv */
// switch_port_error_timeout_regs_test.sv: directed bench for spe_regs.
// assumes the root model and the bound checker.
`timescale 1ns/1ns
module switch_port_error_timeout_regs_test;
  reg ref_clk = 1'h0;
  reg rst = 1'h1;
  reg [11:0] paddr = 12'h000;
  reg psel = 1'h0, penable = 1'h0, pwrite = 1'h0, port_irq_en = 1'h0;
  reg [31:0] pwdata = 32'h0;
  reg [3:0] ev = 4'h0, lag = 4'h0; // ev: cpl, np, posted, parity
  wire [31:0] prdata;
  wire pready, pslverr, p_discard, np_discard, cpl_discard, msg_valid, int_req, irq;
  wire msg_ack, int_ack;
  wire [1:0] msg_sev, last_sev;
  wire [7:0] msg_cnt, int_cnt;
  reg [31:0] rv;
  reg [2:0] dv;
  reg [7:0] m;
  integer err_count = 0, total_checks = 0, i, n;
  spe_regs spe_regs_inst (.ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .parity_err(ev[0]), .p_stale(ev[1]), .np_stale(ev[2]),
    .cpl_stale(ev[3]), .port_irq_en(port_irq_en), .msg_ack(msg_ack), .int_ack(int_ack),
    .p_discard(p_discard), .np_discard(np_discard), .cpl_discard(cpl_discard),
    .msg_valid(msg_valid), .msg_sev(msg_sev), .int_req(int_req), .irq(irq));
  spe_root spe_root_inst (.ref_clk(ref_clk), .rst(rst), .msg_valid(msg_valid),
    .msg_sev(msg_sev), .int_req(int_req), .lag(lag), .msg_ack(msg_ack), .int_ack(int_ack),
    .msg_cnt(msg_cnt), .int_cnt(int_cnt), .last_sev(last_sev));
  initial forever #4 ref_clk = ~ref_clk;
  task give_verdict; begin
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  end endtask
  task chk(input [31:0] s, input [31:0] e); begin
    total_checks = total_checks + 1;
    if (s !== e) begin
      err_count = err_count + 1;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  end endtask
  // one apb transfer; the wait for ready is bounded
  task apb(input [11:0] a, input w, input [31:0] d); begin
    @(posedge ref_clk) {paddr, pwrite, pwdata, psel} <= {a, w, d, 1'h1};
    @(posedge ref_clk) penable <= 1'h1;
    n = 0;
    do begin @(posedge ref_clk); n = n + 1; end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin err_count = err_count + 1; give_verdict; end
    rv = pready & pslverr ? 32'hBAD : prdata;
    {psel, penable} <= 2'h0;
  end endtask
  task pulse(input [3:0] e); begin
    @(posedge ref_clk) ev <= e;
    @(posedge ref_clk) ev <= 4'h0;
    #1 dv = {cpl_discard, np_discard, p_discard};
  end endtask
  task t_reset; begin
    apb(12'h4DC, 0, 0); chk(rv, 2);
    apb(12'h4E4, 0, 0); chk(rv, 1);
    apb(12'h4E8, 0, 0); chk(rv, 2);
    apb(12'h4FC, 0, 0); chk(rv, 32'hBAD); // unmapped place refused
  end endtask
  // every report code; a second error while the flag is set stays quiet
  task t_parity; begin
    for (i = 0; i < 4; i = i + 1) begin
      apb(12'h4DC, 1, i);
      m = msg_cnt;
      pulse(4'h1);
      pulse(4'h1);
      repeat (12) @(posedge ref_clk);
      chk(msg_cnt, m + (i != 0));
      if (i != 0) chk(last_sev, i);
      apb(12'h4D8, 0, 0); chk(rv, 1);
      apb(12'h4D8, 1, 1);
      apb(12'h4D8, 0, 0); chk(rv, 0);
      apb(12'h4E0, 0, 0); chk(rv, 2);
    end
  end endtask
  task t_quiet; begin
    apb(12'h4DC, 1, 0);
    apb(12'h4D4, 1, 1);
    pulse(4'h1);
    apb(12'h4D8, 0, 0); chk(rv, 0);
    apb(12'h4E0, 0, 0); chk(rv, 0);
    apb(12'h4D4, 1, 0);
    repeat (300) pulse(4'h1);
    apb(12'h4E0, 0, 0); chk(rv, 32'hFF);
    apb(12'h4E0, 0, 0); chk(rv, 0);
    apb(12'h4D8, 1, 1);
  end endtask
  // slow root; fields posted=1 nonposted=3 completion=2
  task t_timeout; begin
    lag <= 4'h3;
    apb(12'h4E8, 1, 32'h2D);
    for (i = 0; i < 3; i = i + 1) begin
      m = msg_cnt;
      pulse(4'h2 << i); chk(dv, 3'h1 << i);
      pulse(4'h2 << i);
      repeat (12) @(posedge ref_clk);
      chk(msg_cnt, m + 1);
      chk(last_sev, (32'h2D >> (2 * i)) & 3);
    end
    apb(12'h4EC, 0, 0); chk(rv, 32'h20202);
    apb(12'h4E4, 1, 0);
    pulse(4'hE); chk(dv, 0);
    apb(12'h4E4, 1, 1);
  end endtask
  task t_irq; begin
    port_irq_en <= 1'h1;
    apb(12'h4F4, 1, 32'hF);
    apb(12'h4F8, 1, 1);
    apb(12'h4DC, 1, 4);
    m = int_cnt;
    pulse(4'h1);
    repeat (6) @(posedge ref_clk);
    #1 chk(irq, 1);
    chk(int_cnt, m + 1);
    apb(12'h4F4, 1, 1);
    apb(12'h4F8, 1, 0);
    // posted status is still set from the time-out scenario; clear it first
    apb(12'h4F0, 1, 7);
    apb(12'h4F0, 0, 0); chk(rv, 0);
    pulse(4'h2);
    repeat (3) @(posedge ref_clk);
    #1 chk(irq, 0);
    apb(12'h4F4, 0, 0); chk(rv, 2);
    apb(12'h4F0, 0, 0); chk(rv, 1);
  end endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'h0;
    t_reset;
    t_parity;
    t_quiet;
    t_timeout;
    t_irq;
    give_verdict;
  end
endmodule // switch_port_error_timeout_regs_test
